// ==== shared/amc_params.svh ====
// Purpose: Register indices, field positions, reset values and timing counts.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// -----------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------
`define AMC_IDX_CHMODE      8'h07
`define AMC_IDX_DLCTRL      8'h0f
`define AMC_IDX_MASK        8'h14
`define AMC_IDX_MUTECTRL    8'h1a
`define AMC_IDX_STATUS      8'h65

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define AMC_BIT_MULTICH     6
`define AMC_BIT_DL_MANUAL   7
`define AMC_BIT_DL_SKIP     6
`define AMC_FLD_SPEED_HI    4
`define AMC_BIT_FORCE       4
`define AMC_FLD_WAIT_HI     3
`define AMC_FLD_WAIT_LO     1
`define AMC_BIT_HOLD        0
`define AMC_BIT_MUTE_RAW    6
`define AMC_BIT_LAYOUT_RAW  4

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define AMC_RST_SPEED       5'h1f
`define AMC_RST_WAIT        3'h0
`define AMC_RST_MASK        18'h00000

// -----------------------------------------------------------------------
// Timing and ramp
// -----------------------------------------------------------------------
`define AMC_CLK_MHZ         200
`define AMC_WAIT_STEP_MS    250
`define AMC_WAIT_STEP_CYC   (`AMC_WAIT_STEP_MS * 1000 * `AMC_CLK_MHZ)
`define AMC_WAIT_MAX_SEL    3'h4
`define AMC_DL_DEPTH        512
`define AMC_RAMP_SILENT     7'h60
`define AMC_DSD_MUTE_PAT    6'h15

`endif

// ==== shared/amc_pkg.sv ====
// Purpose: Types shared by the audio mute controller.
// Assumes: Nothing beyond the parameter header.
// Notes:   Sample width is fixed here at 24 bits.
package amc_pkg;

	typedef struct packed {
		logic        valid;
		logic [23:0] left;
		logic [23:0] right;
	} amc_smp_t;

	typedef struct packed {
		logic is_asp;
		logic is_dsd;
		logic is_hbr;
		logic compressed;
		logic layout;
		logic multich;
	} amc_pkt_t;

	typedef enum logic [1:0] {
		AMC_ST_PASS = 2'b00,
		AMC_ST_MUTE = 2'b01,
		AMC_ST_WAIT = 2'b11
	} amc_state_t;

endpackage

// ==== rtl/amc_top.sv ====
// Purpose: Audio mute subsystem: delay line, mute controller, ramped mute.
// Assumes: One clock; samples arrive as one-cycle valid strobes.
// Notes:   Registers over APB, index times four gives the byte address.
`timescale 1ns/1ps
`default_nettype none
`include "amc_params.svh"

// Summary of operation
// - Layout status bit is inverse of layout.
// - Layout bit updates for sample and DSD.
// - Multichannel flag reports uncompressed channels three-eight.
// - Stereo channels delayed by 512 samples.
// - Controller makes mute and coast requests.
// - Ramp fades to silence gradually.
// - Ramp touches only uncompressed sample packets.
// - Delay bypassed for multichannel, DSD, HBR.
// - Ramp bypassed for compressed, DSD, HBR.
// - Manual select zero means automatic delay control.
// - Skip bit bypasses delay under manual.
// - Unmute needs clear conditions, no hold, wait.
// - Muted DSD becomes alternating 0101 pattern.
// - Muted compressed or HBR outputs zeros.
// - Force bit mutes regardless of masks.
// - Interval sets samples per 1.5 dB step.
// - Hold bit blocks automatic unmute.
// - Wait field adds 250 ms multiples.
// - Masked conditions trigger the internal mute.
// - Raw status shows internal mute state.
module amc_top
	import amc_pkg::*;
#(
	parameter int          COND_N        = 18,
	parameter int unsigned WAIT_STEP_CYC = `AMC_WAIT_STEP_CYC
) (
	// Clock and reset
	input  wire logic              SYS_CLK_I,
	input  wire logic              RESETN_I,
	// APB slave
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [11:0]       PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	// Audio input side
	input  wire amc_smp_t          SMP_I,
	input  wire amc_pkt_t          PKT_I,
	input  wire logic [5:0]        DSD_I,
	input  wire logic [3:0]        HBR_I,
	input  wire logic [COND_N-1:0] MUTE_COND_I,
	// Audio output side
	output amc_smp_t               SMP_O,
	output logic      [5:0]        DSD_O,
	output logic      [3:0]        HBR_O,
	output logic                   COAST_O,
	output logic                   MUTE_O
);

	// -------------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------------
	logic              dl_manual_r;
	logic              dl_skip_r;
	logic [4:0]        speed_r;
	logic              force_r;
	logic [2:0]        wait_sel_r;
	logic              hold_r;
	logic [COND_N-1:0] mask_r;
	logic              layout_raw_r;
	logic              multich_r;
	logic [31:0]       rdata_nxt;
	logic              rd_err_nxt;

	// -------------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------------
	wire logic [7:0] idx      = PADDR_I[9:2];
	wire logic       in_range = (PADDR_I[11:10] == 2'h0) && (PADDR_I[1:0] == 2'h0);
	wire logic       hit_ch   = in_range && (idx == `AMC_IDX_CHMODE);
	wire logic       hit_dl   = in_range && (idx == `AMC_IDX_DLCTRL);
	wire logic       hit_mask = in_range && (idx == `AMC_IDX_MASK);
	wire logic       hit_mc   = in_range && (idx == `AMC_IDX_MUTECTRL);
	wire logic       hit_st   = in_range && (idx == `AMC_IDX_STATUS);
	wire logic       hit_any  = hit_ch | hit_dl | hit_mask | hit_mc | hit_st;
	wire logic       setup    = PSEL_I && !PENABLE_I;
	wire logic       wr_take  = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && hit_any;
	wire logic       mute_raw;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		rd_err_nxt = !hit_any;
		if (hit_ch) begin
			rdata_nxt[`AMC_BIT_MULTICH] = multich_r;
		end
		if (hit_dl) begin
			rdata_nxt[`AMC_BIT_DL_MANUAL] = dl_manual_r;
			rdata_nxt[`AMC_BIT_DL_SKIP] = dl_skip_r;
			rdata_nxt[`AMC_FLD_SPEED_HI:0] = speed_r;
		end
		if (hit_mask) begin
			rdata_nxt[COND_N-1:0] = mask_r;
		end
		if (hit_mc) begin
			rdata_nxt[`AMC_BIT_FORCE] = force_r;
			rdata_nxt[`AMC_FLD_WAIT_HI:`AMC_FLD_WAIT_LO] = wait_sel_r;
			rdata_nxt[`AMC_BIT_HOLD] = hold_r;
		end
		if (hit_st) begin
			rdata_nxt[`AMC_BIT_MUTE_RAW] = mute_raw;
			rdata_nxt[`AMC_BIT_LAYOUT_RAW] = layout_raw_r;
		end
	end

	// The answer is prepared in the setup cycle so the access phase never waits.
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= setup;
			PSLVERR_O <= setup && rd_err_nxt;
			if (setup) begin
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rdata_nxt;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dl_manual_r <= 1'b0;
			dl_skip_r   <= 1'b0;
			speed_r     <= `AMC_RST_SPEED;
			force_r     <= 1'b0;
			wait_sel_r  <= `AMC_RST_WAIT;
			hold_r      <= 1'b0;
			mask_r      <= COND_N'(`AMC_RST_MASK);
		end else if (wr_take) begin
			if (hit_dl) begin
				dl_manual_r <= PWDATA_I[`AMC_BIT_DL_MANUAL];
				dl_skip_r   <= PWDATA_I[`AMC_BIT_DL_SKIP];
				speed_r     <= PWDATA_I[`AMC_FLD_SPEED_HI:0];
			end
			if (hit_mask) begin
				mask_r <= PWDATA_I[COND_N-1:0];
			end
			if (hit_mc) begin
				force_r    <= PWDATA_I[`AMC_BIT_FORCE];
				wait_sel_r <= PWDATA_I[`AMC_FLD_WAIT_HI:`AMC_FLD_WAIT_LO];
				hold_r     <= PWDATA_I[`AMC_BIT_HOLD];
			end
		end
	end

	// -------------------------------------------------------------------
	// Packet status
	// -------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			layout_raw_r <= 1'b0;
			multich_r    <= 1'b0;
		end else begin
			if (SMP_I.valid && (PKT_I.is_asp || PKT_I.is_dsd)) begin
				layout_raw_r <= !PKT_I.layout;
			end
			multich_r <= PKT_I.multich && !PKT_I.compressed;
		end
	end

	// -------------------------------------------------------------------
	// Mute controller
	// -------------------------------------------------------------------
	amc_state_t  state_r;
	amc_state_t  state_nxt;
	logic [27:0] wait_cnt_r;
	logic [27:0] wait_cnt_nxt;

	wire logic        cond_act  = |(MUTE_COND_I & mask_r);
	wire logic        mute_set  = cond_act || force_r;
	// Selects above four are held at four; the counter is sized for that longest wait.
	wire logic [2:0]  wait_eff  = (wait_sel_r > `AMC_WAIT_MAX_SEL) ? `AMC_WAIT_MAX_SEL : wait_sel_r;
	wire logic [27:0] wait_load = 28'(WAIT_STEP_CYC * wait_eff);
	assign mute_raw = (state_r != AMC_ST_PASS);

	// Leaving mute needs clear conditions, no hold, and an expired wait.
	always_comb begin
		state_nxt = state_r;
		wait_cnt_nxt = wait_cnt_r;
		unique case (state_r)
			AMC_ST_PASS: begin
				if (mute_set) begin
					state_nxt = AMC_ST_MUTE;
				end
			end
			AMC_ST_MUTE: begin
				wait_cnt_nxt = wait_load;
				if (!mute_set && !hold_r) begin
					state_nxt = (wait_load == 28'h0) ? AMC_ST_PASS : AMC_ST_WAIT;
				end
			end
			AMC_ST_WAIT: begin
				if (mute_set || hold_r) begin
					state_nxt = AMC_ST_MUTE;
				end else if (wait_cnt_r <= 28'h1) begin
					state_nxt = AMC_ST_PASS;
				end else begin
					wait_cnt_nxt = wait_cnt_r - 28'h1;
				end
			end
			default: begin
				state_nxt = AMC_ST_MUTE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_r    <= AMC_ST_PASS;
			wait_cnt_r <= 28'h0;
		end else begin
			state_r    <= state_nxt;
			wait_cnt_r <= wait_cnt_nxt;
		end
	end

	// -------------------------------------------------------------------
	// Delay line
	// -------------------------------------------------------------------
	logic [47:0] dl_mem [`AMC_DL_DEPTH];
	logic [8:0]  dl_ptr_r;
	logic [47:0] dl_old_r;
	amc_smp_t    in_d_r;
	amc_pkt_t    pkt_d_r;

	// Automatic mode opens the line for stereo only.
	wire logic auto_skip = PKT_I.multich || PKT_I.is_dsd || PKT_I.is_hbr;
	wire logic dl_skip   = dl_manual_r ? dl_skip_r : auto_skip;

	// The line keeps filling while bypassed, so re-enabling it yields history.
	always_ff @(posedge SYS_CLK_I) begin
		if (SMP_I.valid) begin
			dl_mem[dl_ptr_r] <= {SMP_I.left, SMP_I.right};
			dl_old_r <= dl_mem[dl_ptr_r];
		end
	end

	logic dl_skip_d_r;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dl_ptr_r    <= 9'h000;
			in_d_r      <= '0;
			pkt_d_r     <= '0;
			dl_skip_d_r <= 1'b0;
		end else begin
			if (SMP_I.valid) begin
				dl_ptr_r <= dl_ptr_r + 9'h001;
			end
			in_d_r      <= SMP_I;
			pkt_d_r     <= PKT_I;
			dl_skip_d_r <= dl_skip;
		end
	end

	wire logic [23:0] sel_l = dl_skip_d_r ? in_d_r.left  : dl_old_r[47:24];
	wire logic [23:0] sel_r = dl_skip_d_r ? in_d_r.right : dl_old_r[23:0];

	// -------------------------------------------------------------------
	// Ramped mute
	// -------------------------------------------------------------------
	logic [6:0] atten_r;
	logic [4:0] step_cnt_r;

	// Gain is 2^(-k/4): a quarter-octave mantissa then a shift.
	function automatic logic [23:0] amc_scale(input logic [23:0] x, input logic [6:0] k);
		logic signed [33:0] prod;
		logic        [8:0]  mant;
		mant = 9'h100;
		unique case (k[1:0])
			2'h0: mant = 9'h100;
			2'h1: mant = 9'h0d7;
			2'h2: mant = 9'h0b5;
			2'h3: mant = 9'h098;
		endcase
		prod = 34'(signed'(x)) * signed'({1'b0, mant});
		prod = prod >>> 8;
		prod = prod >>> k[6:2];
		return prod[23:0];
	endfunction

	wire logic ramp_bypass = pkt_d_r.compressed || pkt_d_r.is_dsd || pkt_d_r.is_hbr;
	wire logic ramp_tick   = in_d_r.valid && pkt_d_r.is_asp &&
		(step_cnt_r + 5'h01 >= ((speed_r == 5'h00) ? 5'h01 : speed_r));

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			atten_r    <= 7'h00;
			step_cnt_r <= 5'h00;
		end else if (in_d_r.valid) begin
			step_cnt_r <= ramp_tick ? 5'h00 : step_cnt_r + 5'h01;
			if (ramp_tick && mute_raw && atten_r < `AMC_RAMP_SILENT) begin
				atten_r <= atten_r + 7'h01;
			end else if (ramp_tick && !mute_raw && atten_r != 7'h00) begin
				atten_r <= atten_r - 7'h01;
			end
		end
	end

	// -------------------------------------------------------------------
	// Output stage
	// -------------------------------------------------------------------
	wire logic        silent  = (atten_r >= `AMC_RAMP_SILENT);
	wire logic [23:0] ramp_l  = silent ? 24'h000000 : amc_scale(sel_l, atten_r);
	wire logic [23:0] ramp_r  = silent ? 24'h000000 : amc_scale(sel_r, atten_r);
	wire logic        zero_bp = ramp_bypass && mute_raw;
	wire logic [23:0] out_l   = zero_bp ? 24'h000000 : (ramp_bypass ? sel_l : ramp_l);
	wire logic [23:0] out_r   = zero_bp ? 24'h000000 : (ramp_bypass ? sel_r : ramp_r);

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			SMP_O <= '0;
		end else begin
			SMP_O.valid <= in_d_r.valid;
			SMP_O.left  <= out_l;
			SMP_O.right <= out_r;
		end
	end

	// -------------------------------------------------------------------
	// DSD and HBR lanes
	// -------------------------------------------------------------------
	// Complementary words on alternate cycles keep each lane's decoded mean at zero.
	wire logic [5:0] dsd_pat_nxt = (DSD_O == `AMC_DSD_MUTE_PAT) ?
		~`AMC_DSD_MUTE_PAT : `AMC_DSD_MUTE_PAT;
	wire logic [5:0] dsd_nxt     = mute_raw ? dsd_pat_nxt : DSD_I;
	wire logic [3:0] hbr_nxt     = mute_raw ? 4'h0 : HBR_I;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DSD_O <= 6'h00;
			HBR_O <= 4'h0;
		end else begin
			DSD_O <= dsd_nxt;
			HBR_O <= hbr_nxt;
		end
	end

	// -------------------------------------------------------------------
	// Controller outputs
	// -------------------------------------------------------------------
	// Coast follows the conditions only, so a forced mute never stalls the clock loop.
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			COAST_O <= 1'b0;
			MUTE_O  <= 1'b0;
		end else begin
			COAST_O <= cond_act;
			MUTE_O  <= mute_raw;
		end
	end

endmodule

`default_nettype wire

// ==== testbench/amc_src.sv ====
// Purpose: Packet decoder model feeding the audio inputs.
// Assumes: One sample strobe every fourth clock.
// Notes:   Samples and lanes are random; the lanes and the sample strobe stay quiet in reset.
`timescale 1ns/1ps
`default_nettype none
module amc_src
	import amc_pkg::*;
(
	// Clock and packet kind
	input  wire logic     clk_i,
	input  wire logic     rstn_i,
	input  wire amc_pkt_t pkt_i,
	// Decoded stream
	output amc_smp_t      smp_o = '0,
	output amc_pkt_t      pkt_o = '0,
	output logic [5:0]    dsd_o = 6'h00,
	output logic [3:0]    hbr_o = 4'h0
);
	integer     seed = 32'heb8803f5;
	logic [1:0] ph_r = 2'h0;
	// ----------------------------------------------------------------
	// Stream
	// ----------------------------------------------------------------
	// Strobes four cycles apart keep the required spacing with margin.
	always @(posedge clk_i) begin
		ph_r  <= ph_r + 2'h1;
		pkt_o <= pkt_i;
		dsd_o <= rstn_i ? 6'($random(seed)) : 6'h00;
		hbr_o <= rstn_i ? 4'($random(seed)) : 4'h0;
		smp_o <= {rstn_i && ph_r == 2'h0, 24'($random(seed)), 24'($random(seed))};
	end
endmodule
`default_nettype wire

// ==== testbench/amc_chk.sv ====
// Purpose: Port assertions for the audio mute block.
// Assumes: Mute state is seen through MUTE_O only.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module amc_chk
	import amc_pkg::*;
#(
	parameter int COND_N = 18
) (
	// Clock, reset and bus
	input wire logic              SYS_CLK_I,
	input wire logic              RESETN_I,
	input wire logic              PSEL_I,
	input wire logic              PENABLE_I,
	input wire logic              PREADY_O,
	// Audio
	input wire logic [COND_N-1:0] MUTE_COND_I,
	input wire amc_smp_t          SMP_I,
	input wire logic [3:0]        HBR_I,
	input wire amc_smp_t          SMP_O,
	input wire logic [5:0]        DSD_O,
	input wire logic [3:0]        HBR_O,
	input wire logic              COAST_O,
	input wire logic              MUTE_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	ready_pulse_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
		else $error("ready is not one pulse");
	smp_lat_a: assert property (SMP_O.valid == $past(SMP_I.valid, 2))
		else $error("sample strobe latency wrong");
	coast_idle_a: assert property (!(|MUTE_COND_I) |=> !COAST_O)
		else $error("coast without condition");
	mute_rise_a: assert property ($rose(COAST_O) |-> ##[0:2] MUTE_O)
		else $error("condition did not mute");
	mute_fall_a: assert property ($fell(MUTE_O) |-> !COAST_O)
		else $error("unmute with active condition");
	hbr_zero_a: assert property (MUTE_O && $past(MUTE_O) |-> HBR_O == 4'h0)
		else $error("muted lanes not zero");
	hbr_pass_a: assert property ($past(RESETN_I) && !MUTE_O && !$past(MUTE_O)
		|-> HBR_O == $past(HBR_I))
		else $error("lanes not passed through");
	// Two muted cycles back are needed before the toggle can be judged.
	dsd_pat_a: assert property (MUTE_O && $past(MUTE_O) && $past(MUTE_O, 2)
		|-> (DSD_O == 6'h2a || DSD_O == 6'h15) && DSD_O != $past(DSD_O))
		else $error("muted lanes not alternating");
endmodule
bind amc_top amc_chk #(.COND_N(COND_N)) u_chk (
	.SYS_CLK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PREADY_O, .MUTE_COND_I,
	.SMP_I, .HBR_I, .SMP_O, .DSD_O, .HBR_O, .COAST_O, .MUTE_O
);
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the audio mute block.
// Assumes: Wait step shortened to 20 cycles.
// Notes:   A sample model is compared at every output sample when enabled.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import amc_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd;
	logic [17:0] cond = 18'h0;
	amc_pkt_t    pkt = '0, pkt_d;
	logic        dly_x = 1'b0, zero_x = 1'b0, cmp_en = 1'b0;
	logic        prdy, perr, perr_l, coast, mute;
	amc_smp_t    smp_i, smp_o;
	logic [5:0]  dsd_i, dsd_o;
	logic [3:0]  hbr_i, hbr_o;
	logic [47:0] rd, hist[$];
	logic [14:0] dtab[6] = '{{8'h1f, 6'h22, 1'b1}, {8'h1f, 6'h21, 1'b0},
		{8'h1f, 6'h12, 1'b0}, {8'h1f, 6'h0a, 1'b0}, {8'h9f, 6'h21, 1'b1},
		{8'hdf, 6'h22, 1'b0}};
	int          err_count = 0, total_checks = 0, i, n;
	always #2.5 clk = ~clk;
	amc_src u_src (.clk_i(clk), .rstn_i(rstn), .pkt_i(pkt), .smp_o(smp_i), .pkt_o(pkt_d),
		.dsd_o(dsd_i), .hbr_o(hbr_i));
	amc_top #(.WAIT_STEP_CYC(20)) u_dut (.SYS_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(prdy), .PSLVERR_O(perr), .SMP_I(smp_i), .PKT_I(pkt_d), .DSD_I(dsd_i),
		.HBR_I(hbr_i), .MUTE_COND_I(cond), .SMP_O(smp_o), .DSD_O(dsd_o), .HBR_O(hbr_o),
		.COAST_O(coast), .MUTE_O(mute));
	// ----------------------------------------------------------------
	// Tasks and sample model
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic fail(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
		final_report;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		padr <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 20);
		if (prdy !== 1'b1) fail("bus timeout");
		else begin
			rd = 48'(prd);
			perr_l = perr;
			psel <= 1'b0;
			pen  <= 1'b0;
		end
	endtask
	task automatic wmute(input logic v, input int lim);
		for (n = 0; mute !== v; n++)
			if (n == lim) fail("mute wait");
			else @(posedge clk);
	endtask
	always @(posedge clk) begin
		if (smp_i.valid) hist.push_back({smp_i.left, smp_i.right});
		if (smp_o.valid && cmp_en) chk({smp_o.left, smp_o.right}, zero_x ? 48'h0
			: hist[hist.size() - (dly_x ? 513 : 1)], "sample");
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 12'h03c, 32'h0);
		chk(rd, 48'h1f, "ctrl reset");
		apb(1'b0, 12'h068, 32'h0);
		chk(rd, 48'h0, "mute reset");
		apb(1'b1, 12'h01c, 32'hffffffff);
		apb(1'b0, 12'h010, 32'h0);
		chk(48'({perr_l, rd[31:0]}), 48'h100000000, "unmapped");
		$display("registers done");
		for (i = 0; i < 16; i++) begin
			pkt <= amc_pkt_t'({~i[3], i[3], 1'b0, i[2], i[1], i[0]});
			repeat (12) @(posedge clk);
			apb(1'b0, 12'h194, 32'h0);
			chk(rd, 48'(!i[1]) << 4, "layout");
			apb(1'b0, 12'h01c, 32'h0);
			chk(rd, 48'(i[0] && !i[2]) << 6, "multichannel");
		end
		$display("layout done");
		// The delay line must hold a full history before old samples are judged.
		repeat (2100) @(posedge clk);
		for (i = 0; i < 6; i++) begin
			cmp_en <= 1'b0;
			apb(1'b1, 12'h03c, 32'(dtab[i][14:7]));
			apb(1'b0, 12'h03c, 32'h0);
			chk(rd, 48'(dtab[i][14:7]), "ctrl");
			pkt   <= amc_pkt_t'(dtab[i][6:1]);
			dly_x <= dtab[i][0];
			repeat (16) @(posedge clk);
			cmp_en <= 1'b1;
			repeat (40) @(posedge clk);
		end
		$display("delay done");
		cmp_en <= 1'b0;
		dly_x  <= 1'b0;
		apb(1'b1, 12'h03c, 32'hc1);
		for (i = 0; i < 2; i++) begin
			pkt <= amc_pkt_t'(i ? 6'h26 : 6'h22);
			apb(1'b1, 12'h068, 32'h10);
			wmute(1'b1, 10);
			apb(1'b0, 12'h194, 32'h0);
			chk(rd, 48'h40, "status");
			zero_x <= 1'b1;
			repeat (i ? 12 : 440) @(posedge clk);
			cmp_en <= 1'b1;
			repeat (40) @(posedge clk);
			cmp_en <= 1'b0;
			apb(1'b1, 12'h068, 32'h0);
			wmute(1'b0, 10);
			zero_x <= 1'b0;
			repeat (i ? 12 : 440) @(posedge clk);
			cmp_en <= 1'b1;
			repeat (40) @(posedge clk);
			cmp_en <= 1'b0;
		end
		$display("ramp done");
		apb(1'b1, 12'h03c, 32'h1f);
		apb(1'b1, 12'h050, 32'h3ffff);
		apb(1'b0, 12'h050, 32'h0);
		chk(rd, 48'h3ffff, "mask");
		for (i = 0; i < 18; i++) begin
			cond <= 18'h1 << i;
			wmute(1'b1, 10);
			chk(48'(coast), 48'h1, "coast");
			cond <= 18'h0;
			wmute(1'b0, 10);
		end
		apb(1'b1, 12'h050, 32'h1);
		cond <= 18'h3fffe;
		repeat (20) @(posedge clk);
		chk(48'(mute), 48'h0, "unmasked");
		apb(1'b1, 12'h068, 32'h1);
		cond <= 18'h1;
		wmute(1'b1, 10);
		cond <= 18'h0;
		repeat (60) @(posedge clk);
		chk(48'(mute), 48'h1, "hold");
		apb(1'b1, 12'h068, 32'h0);
		apb(1'b1, 12'h068, 32'h1);
		wmute(1'b0, 10);
		$display("conditions done");
		for (i = 1; i < 5; i++) begin
			apb(1'b1, 12'h068, 32'(i) << 1);
			cond <= 18'h1;
			wmute(1'b1, 10);
			cond <= 18'h0;
			repeat (10) @(posedge clk);
			cond <= 18'h1;
			@(posedge clk);
			cond <= 18'h0;
			wmute(1'b0, i * 20 + 8);
			chk(48'(n >= i * 20), 48'h1, "wait");
		end
		$display("wait done");
		final_report;
	end
endmodule
`default_nettype wire
